/* hdl/wcc_top.sv */
// Wiper command interpreter: input and wiper registers, modes, protection
`timescale 1ns/100ps
module wcc_top
  import wcc_pkg::*;
#(
  parameter int RELOAD_COUNT = RELOAD_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Command port from serial front end
  input wire logic cmd_valid_in,
  input wire wcc_cmd_type cmd_in,
  input wire logic frame_start_in,
  // Pins
  input wire logic load_wiper_pin_n_in,
  input wire logic independent_mode_pin_in,
  input wire logic reset_pin_n_in,
  input wire logic write_protect_pin_n_in,
  // Stored values from nonvolatile memory
  input wire logic [7:0] nvm_wb_in,
  input wire logic [7:0] nvm_aw_in,
  // Outputs
  output logic busy_out,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  output wcc_wiper_type wiper_out,
  output logic linear_mode_out,
  output logic burst_active_out,
  output logic nvm_program_enable_out,
  output logic [3:0] control_out
);
  logic load_n_s;
  logic independent_mode_pin_s;
  logic rst_pin_n_s;
  logic wp_n_s;
  logic [3:0] pins_s;

  wcc_sync #(.WIDTH(4), .INIT(4'hB)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(clk_en_in),
    .async_in({load_wiper_pin_n_in, independent_mode_pin_in, reset_pin_n_in,
               write_protect_pin_n_in}),
    .sync_out(pins_s)
  );
  assign load_n_s = pins_s[3];
  assign independent_mode_pin_s = pins_s[2];
  assign rst_pin_n_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // Index 0 is the lower string, index 1 the upper string
  logic [7:0] wiper_r [2];
  logic [7:0] wiper_nxt [2];
  logic [7:0] input_r [2];
  logic [7:0] input_nxt [2];
  logic [7:0] step_val [2];
  logic [3:0] ctl_r, ctl_nxt;
  logic top_r, top_nxt, bot_r, bot_nxt, sd_r, sd_nxt, sd_sel_r, sd_sel_nxt;
  logic wp_r, wp_nxt, load_prev_r, load_prev_nxt, rst_prev_r, rst_prev_nxt;
  logic burst_r, burst_nxt, independent_mode_pin_lat_r, independent_mode_pin_lat_nxt, boot_r, boot_nxt;
  logic [4:0] burst_code_r, burst_code_nxt;
  logic [14:0] cnt_r, cnt_nxt;
  wcc_state_type state_r, state_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic rd_v_r, rd_v_nxt;
  wcc_wiper_type wout_r, wout_nxt;
  wcc_cmd_type cmd;
  logic linear, wiper_ok, load_fall, rst_fall;

  assign linear = ctl_r[CTL_LINEAR_POS] | independent_mode_pin_lat_r;
  assign wiper_ok = ctl_r[CTL_WIPER_WE_POS] & ~wp_r;
  assign load_fall = load_prev_r & ~load_n_s;
  assign rst_fall = rst_prev_r & ~rst_pin_n_s;

  always_comb begin
    cmd = cmd_in;
    if (burst_r) begin
      cmd.code = burst_code_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_step
      wcc_step u_step (
        .code_in(cmd.code),
        .value_in(wiper_r[g]),
        .value_out(step_val[g])
      );
    end
  endgenerate

  always_comb begin
    wiper_nxt = wiper_r;
    input_nxt = input_r;
    ctl_nxt = ctl_r;
    top_nxt = top_r;
    bot_nxt = bot_r;
    sd_nxt = sd_r;
    sd_sel_nxt = sd_sel_r;
    wp_nxt = wp_r;
    burst_nxt = burst_r;
    burst_code_nxt = burst_code_r;
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    independent_mode_pin_lat_nxt = independent_mode_pin_lat_r;
    boot_nxt = 1'b0;
    rd_nxt = rd_r;
    rd_v_nxt = 1'b0;
    load_prev_nxt = load_n_s;
    rst_prev_nxt = rst_pin_n_s;
    if (state_r == ST_RELOAD && int'(cnt_r) >= RELOAD_COUNT - 1) begin
      independent_mode_pin_lat_nxt = independent_mode_pin_s;
    end
    if (frame_start_in) begin
      burst_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        wp_nxt = ~wp_n_s;
        if (boot_r || rst_fall) begin
          state_nxt = ST_RELOAD;
          cnt_nxt = '0;
          ctl_nxt[CTL_BURST_POS] = 1'b0;
          burst_nxt = 1'b0;
        end else if (cmd_valid_in) begin
          state_nxt = ST_EXEC;
          if (ctl_r[CTL_BURST_POS] && !burst_r && !frame_start_in) begin
            burst_nxt = 1'b1;
            burst_code_nxt = cmd_in.code;
          end
          for (int i = 0; i < 2; i++) begin
            if (cmd.all_ch || (cmd.sel_aw == i[0] && (linear || i == 0))) begin
              case (cmd.code)
                CMD_WR_INPUT: begin
                  if (wiper_ok) begin
                    input_nxt[i] = cmd.data;
                  end
                end
                CMD_RD_INPUT: begin
                  rd_nxt = input_r[i];
                  rd_v_nxt = 1'b1;
                end
                CMD_INC, CMD_DEC, CMD_SHL, CMD_SHR: begin
                  if (wiper_ok) begin
                    wiper_nxt[i] = step_val[i];
                    input_nxt[i] = step_val[i];
                    top_nxt = 1'b0;
                    bot_nxt = 1'b0;
                  end
                end
                CMD_LOAD: begin
                  if (wiper_ok) begin
                    wiper_nxt[i] = input_r[i];
                    top_nxt = 1'b0;
                    bot_nxt = 1'b0;
                  end
                end
                default: begin
                end
              endcase
            end
          end
          case (cmd.code)
            CMD_TOP: begin
              if (wiper_ok) begin
                top_nxt = cmd.data[DATA_LSB_POS];
                bot_nxt = 1'b0;
              end
            end
            CMD_BOTTOM: begin
              if (wiper_ok) begin
                bot_nxt = cmd.data[DATA_LSB_POS];
                top_nxt = 1'b0;
              end
            end
            CMD_SWRESET: begin
              state_nxt = ST_RELOAD;
              cnt_nxt = '0;
            end
            CMD_SHUTDOWN: begin
              sd_nxt = cmd.data[DATA_LSB_POS];
              sd_sel_nxt = cmd.sel_aw;
              top_nxt = 1'b0;
              bot_nxt = 1'b0;
            end
            CMD_CONTROL: begin
              ctl_nxt = cmd.data[3:0];
            end
            default: begin
            end
          endcase
        end else if (load_fall && wiper_ok) begin
          wiper_nxt = input_r;
          top_nxt = 1'b0;
          bot_nxt = 1'b0;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
      end
      ST_RELOAD: begin
        cnt_nxt = cnt_r + 15'h0001;
        if (int'(cnt_r) >= RELOAD_COUNT - 1) begin
          state_nxt = ST_IDLE;
          wiper_nxt[0] = nvm_wb_in;
          wiper_nxt[1] = nvm_aw_in;
          input_nxt[0] = nvm_wb_in;
          input_nxt[1] = nvm_aw_in;
          top_nxt = 1'b0;
          bot_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Analog switch positions
  always_comb begin
    wout_nxt.aw_code = linear ? wiper_r[1] : wiper_r[0];
    wout_nxt.wb_code = wiper_r[0];
    wout_nxt.aw_pos = POS_CODE;
    wout_nxt.wb_pos = POS_CODE;
    if (sd_r) begin
      if (linear) begin
        wout_nxt.aw_pos = sd_sel_r ? POS_OPEN : POS_CODE;
        wout_nxt.wb_pos = sd_sel_r ? POS_CODE : POS_OPEN;
      end else begin
        wout_nxt.aw_pos = POS_OPEN;
        wout_nxt.wb_pos = POS_LOW;
      end
    end else if (top_r) begin
      wout_nxt.aw_pos = linear ? POS_FULL : POS_LOW;
      wout_nxt.wb_pos = POS_FULL;
    end else if (bot_r) begin
      wout_nxt.aw_pos = linear ? POS_LOW : POS_FULL;
      wout_nxt.wb_pos = POS_LOW;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wiper_r[0] <= CODE_MID;
      wiper_r[1] <= CODE_MID;
      input_r[0] <= CODE_MID;
      input_r[1] <= CODE_MID;
      ctl_r <= CTL_RESET;
      top_r <= 1'b0;
      bot_r <= 1'b0;
      sd_r <= 1'b0;
      sd_sel_r <= 1'b0;
      wp_r <= 1'b0;
      load_prev_r <= 1'b1;
      rst_prev_r <= 1'b1;
      burst_r <= 1'b0;
      burst_code_r <= CMD_NOP;
      cnt_r <= '0;
      state_r <= ST_IDLE;
      independent_mode_pin_lat_r <= 1'b0;
      boot_r <= 1'b1;
      rd_r <= CODE_ZERO;
      rd_v_r <= 1'b0;
      wout_r <= '0;
    end else if (clk_en_in) begin
      wiper_r <= wiper_nxt;
      input_r <= input_nxt;
      ctl_r <= ctl_nxt;
      top_r <= top_nxt;
      bot_r <= bot_nxt;
      sd_r <= sd_nxt;
      sd_sel_r <= sd_sel_nxt;
      wp_r <= wp_nxt;
      load_prev_r <= load_prev_nxt;
      rst_prev_r <= rst_prev_nxt;
      burst_r <= burst_nxt;
      burst_code_r <= burst_code_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
      independent_mode_pin_lat_r <= independent_mode_pin_lat_nxt;
      boot_r <= boot_nxt;
      rd_r <= rd_nxt;
      rd_v_r <= rd_v_nxt;
      wout_r <= wout_nxt;
    end
  end

  logic [3:0] ctl_out_r;
  logic busy_r, lin_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctl_out_r <= CTL_RESET;
      busy_r <= 1'b1;
      lin_r <= 1'b0;
    end else if (clk_en_in) begin
      ctl_out_r <= ctl_nxt;
      busy_r <= (state_nxt != ST_IDLE) | boot_nxt;
      lin_r <= ctl_nxt[CTL_LINEAR_POS] | independent_mode_pin_lat_nxt;
    end
  end

  assign busy_out = busy_r;
  assign read_data_out = rd_r;
  assign read_valid_out = rd_v_r;
  assign wiper_out = wout_r;
  assign linear_mode_out = lin_r;
  assign burst_active_out = burst_r;
  assign nvm_program_enable_out = ctl_out_r[CTL_NVM_PE_POS];
  assign control_out = ctl_out_r;
endmodule

/* hdl/wcc_pkg.sv */
// Package of constants and types for the wiper command control block
package wcc_pkg;

  localparam int WCC_DW = 8;

  // Command codes
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_WR_INPUT = 5'h02;
  localparam logic [4:0] CMD_RD_INPUT = 5'h03;
  localparam logic [4:0] CMD_INC = 5'h04;
  localparam logic [4:0] CMD_DEC = 5'h05;
  localparam logic [4:0] CMD_SHL = 5'h06;
  localparam logic [4:0] CMD_SHR = 5'h07;
  localparam logic [4:0] CMD_LOAD = 5'h08;
  localparam logic [4:0] CMD_TOP = 5'h0C;
  localparam logic [4:0] CMD_BOTTOM = 5'h0D;
  localparam logic [4:0] CMD_SWRESET = 5'h0E;
  localparam logic [4:0] CMD_SHUTDOWN = 5'h0F;
  localparam logic [4:0] CMD_CONTROL = 5'h10;

  // Control register fields and reset value
  localparam int CTL_WIPER_WE_POS = 0;
  localparam int CTL_NVM_PE_POS = 1;
  localparam int CTL_LINEAR_POS = 2;
  localparam int CTL_BURST_POS = 3;
  localparam logic [3:0] CTL_RESET = 4'h3;

  // Data field positions
  localparam int DATA_LSB_POS = 0;
  localparam int DATA_MSB_POS = 7;

  // Code values
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] CODE_ONE = 8'h01;
  localparam logic [7:0] CODE_FULL = 8'hFF;
  localparam logic [7:0] CODE_MID = 8'h80;

  // Reload time from nonvolatile memory
  localparam int CLK_MHZ = 250;
  localparam int RELOAD_US = 30;
  localparam int RELOAD_CYCLES = RELOAD_US * CLK_MHZ;

  // Output position per string
  typedef enum logic [1:0] {
    POS_CODE = 2'h0,
    POS_FULL = 2'h1,
    POS_LOW = 2'h2,
    POS_OPEN = 2'h3
  } wcc_pos_type;

  typedef struct packed {
    logic [4:0] code;
    logic all_ch;
    logic sel_aw;
    logic [7:0] data;
  } wcc_cmd_type;

  typedef struct packed {
    wcc_pos_type aw_pos;
    wcc_pos_type wb_pos;
    logic [7:0] aw_code;
    logic [7:0] wb_code;
  } wcc_wiper_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RELOAD = 2'b11
  } wcc_state_type;

endpackage

/* hdl/wcc_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module wcc_sync
  import wcc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = enable_in ? async_in : meta_r;
    sync_nxt = enable_in ? meta_r : sync_r;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

/* hdl/wcc_step.sv */
// Step arithmetic: linear and 6 dB up and down with saturation
`timescale 1ns/100ps
module wcc_step
  import wcc_pkg::*;
(
  input wire logic [4:0] code_in,
  input wire logic [7:0] value_in,
  output logic [7:0] value_out
);
  always_comb begin
    value_out = value_in;
    case (code_in)
      CMD_INC: begin
        if (value_in != CODE_FULL) begin
          value_out = value_in + CODE_ONE;
        end
      end
      CMD_DEC: begin
        if (value_in != CODE_ZERO) begin
          value_out = value_in - CODE_ONE;
        end
      end
      CMD_SHL: begin
        if (value_in == CODE_ZERO) begin
          value_out = CODE_ONE;
        end else if (value_in[DATA_MSB_POS]) begin
          value_out = CODE_FULL;
        end else begin
          value_out = {value_in[6:0], 1'b0};
        end
      end
      CMD_SHR: begin
        value_out = {1'b0, value_in[7:1]};
      end
      default: begin
        value_out = value_in;
      end
    endcase
  end
endmodule

/* dv/wcc_properties.sv */
// Port-level checks for the wiper command interpreter
`timescale 1ns/100ps
module wcc_properties
  import wcc_pkg::*;
#(
  parameter int RELOAD_COUNT = RELOAD_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic cmd_valid_in,
  input wire wcc_cmd_type cmd_in,
  input wire logic write_protect_pin_n_in,
  input wire logic busy_out,
  input wire logic read_valid_out,
  input wire wcc_wiper_type wiper_out,
  input wire logic linear_mode_out,
  input wire logic [3:0] control_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire [7:0] wb = wiper_out.wb_code;
  sequence s_take(logic [4:0] c);
    cmd_valid_in && clk_en_in && !busy_out && cmd_in.code == c && !cmd_in.sel_aw && !cmd_in.all_ch;
  endsequence
  // Take with wiper updates allowed and protect pin long high
  sequence s_open(logic [4:0] c);
    s_take(c) ##0 (control_out[CTL_WIPER_WE_POS] && write_protect_pin_n_in
      && $past(write_protect_pin_n_in, 5));
  endsequence
  chk_read_answer: assert property (s_take(CMD_RD_INPUT) |=> read_valid_out)
    else $error("read answer missing");
  chk_inc_step: assert property (s_open(CMD_INC) ##0 (wb != CODE_FULL) |-> ##2 wb == $past(wb, 2) + 8'h01)
    else $error("increment wrong");
  chk_dec_floor: assert property (s_take(CMD_DEC) ##0 (wb == CODE_ZERO) |-> ##2 wb == CODE_ZERO)
    else $error("decrement wrapped");
  chk_shl_zero: assert property (s_open(CMD_SHL) ##0 (wb == CODE_ZERO) |-> ##2 wb == CODE_ONE)
    else $error("left shift from zero wrong");
  chk_shr_half: assert property (s_open(CMD_SHR) |-> ##2 wb == ($past(wb, 2) >> 1))
    else $error("right shift wrong");
  chk_scale_keeps: assert property (s_take(CMD_TOP) |-> ##2 wb == $past(wb, 2))
    else $error("scale entry changed code");
  chk_mode_or: assert property (control_out[CTL_LINEAR_POS] |-> ##[0:1] linear_mode_out)
    else $error("linear bit without linear mode");
  chk_burst_reset: assert property (disable iff (1'b0) reset_in && clk_en_in |=> !control_out[CTL_BURST_POS])
    else $error("burst bit survived reset");
  chk_reload_busy: assert property (s_take(CMD_SWRESET) |=> busy_out [*8])
    else $error("reload too short");
endmodule

bind wcc_top wcc_properties #(.RELOAD_COUNT(RELOAD_COUNT)) u_wcc_properties (
  .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .write_protect_pin_n_in(write_protect_pin_n_in), .busy_out(busy_out),
  .read_valid_out(read_valid_out), .wiper_out(wiper_out),
  .linear_mode_out(linear_mode_out), .control_out(control_out)
);

/* dv/wcc_host_model.sv */
// Behavioural host issuing one command per request
`timescale 1ns/100ps
module wcc_host_model
  import wcc_pkg::*;
(
  // Bench side
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic req_in,
  input wire wcc_cmd_type req_cmd_in,
  input wire logic [1:0] gap_in,
  input wire logic frame_in,
  // Command port
  output logic cmd_valid_out,
  output wcc_cmd_type cmd_out,
  output logic frame_start_out,
  output logic done_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    frame_start_out = 1'b0;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (req_in) begin
        @(negedge clk_in);
        frame_start_out = frame_in;
        @(negedge clk_in);
        frame_start_out = 1'b0;
        repeat (gap_in) @(negedge clk_in);
        while (busy_in) @(negedge clk_in);
        cmd_out = req_cmd_in;
        cmd_valid_out = 1'b1;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        // Released lines show the inverse
        cmd_out = ~req_cmd_in;
        @(negedge clk_in);
        while (busy_in) @(negedge clk_in);
        done_out = 1'b1;
        wait (!req_in);
        done_out = 1'b0;
      end
    end
  end
endmodule

/* dv/wiper_command_control_bench.sv */
// Self-checking bench for the wiper command interpreter
`timescale 1ns/100ps
module wiper_command_control_bench;
  import wcc_pkg::*;
  localparam logic [4:0] OPS [4] = '{CMD_INC, CMD_DEC, CMD_SHL, CMD_SHR};
  localparam logic [7:0] CORNERS [3] = '{CODE_ZERO, CODE_MID, CODE_FULL};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic load_n = 1'b1;
  logic wp_n = 1'b1;
  logic independent_mode_pin = 1'b0;
  logic rst_n = 1'b1;
  logic frame = 1'b1;
  logic all_ch = 1'b0;
  logic sel_aw = 1'b0;
  logic req = 1'b0;
  logic [1:0] gap = 2'h0;
  wcc_cmd_type req_cmd = '0;
  wcc_cmd_type cmd;
  wcc_wiper_type wiper;
  logic cmd_valid, frame_start, done, busy, read_valid, linear, burst, nvm_pe;
  logic [7:0] read_data;
  logic [3:0] control;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk_in = ~clk_in;

  wcc_top #(.RELOAD_COUNT(20)) u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .frame_start_in(frame_start),
    .load_wiper_pin_n_in(load_n), .independent_mode_pin_in(independent_mode_pin),
    .reset_pin_n_in(rst_n), .write_protect_pin_n_in(wp_n),
    .nvm_wb_in(CODE_MID), .nvm_aw_in(8'h3C), .busy_out(busy),
    .read_data_out(read_data), .read_valid_out(read_valid), .wiper_out(wiper),
    .linear_mode_out(linear), .burst_active_out(burst),
    .nvm_program_enable_out(nvm_pe), .control_out(control)
  );

  wcc_host_model u_host (
    .clk_in(clk_in), .busy_in(busy), .req_in(req), .req_cmd_in(req_cmd),
    .gap_in(gap), .frame_in(frame), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
    .frame_start_out(frame_start), .done_out(done)
  );

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_val(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_pos(string name, wcc_pos_type exp, wcc_pos_type got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic send(logic [4:0] code, logic [7:0] data);
    @(negedge clk_in);
    req_cmd = '{code, all_ch, sel_aw, data};
    gap = 2'($urandom_range(3));
    req = 1'b1;
    do @(posedge clk_in); while (done !== 1'b1);
    @(negedge clk_in);
    req = 1'b0;
  endtask

  task automatic preset(logic [7:0] v);
    send(CMD_WR_INPUT, v);
    send(CMD_LOAD, 8'h00);
  endtask

  task automatic wait_idle;
    @(negedge clk_in);
    while (busy !== 1'b0) @(negedge clk_in);
    // Wiper outputs trail busy by one cycle
    @(negedge clk_in);
  endtask

  function automatic logic [7:0] step(logic [4:0] c, logic [7:0] v);
    case (c)
      CMD_INC: return (v == CODE_FULL) ? v : v + 8'h01;
      CMD_DEC: return (v == CODE_ZERO) ? v : v - 8'h01;
      CMD_SHL: return (v == CODE_ZERO) ? CODE_ONE : (v[7] ? CODE_FULL : {v[6:0], 1'b0});
      default: return v >> 1;
    endcase
  endfunction

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0] v;
    logic [4:0] op;
    void'($urandom(16));
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    wait_idle();
    check_val("boot_wiper", CODE_MID, wiper.wb_code);
    check_val("boot_control", {4'h0, CTL_RESET}, {4'h0, control});
    check_val("boot_nvm_pe", 8'h01, {7'h00, nvm_pe});
    $display("test boot done");
    for (int i = 0; i < 20; i++) begin
      op = (i < 12) ? OPS[i / 3] : OPS[$urandom_range(3)];
      v = (i < 12) ? CORNERS[i % 3] : 8'($urandom);
      send(CMD_WR_INPUT, v);
      send(CMD_RD_INPUT, 8'h00);
      check_val("input_read", v, read_data);
      send(CMD_LOAD, 8'h00);
      check_val("loaded", v, wiper.wb_code);
      send(op, 8'h00);
      check_val("stepped", step(op, v), wiper.wb_code);
      send(CMD_RD_INPUT, 8'h00);
      check_val("input_copy", step(op, v), read_data);
    end
    $display("test steps done");
    preset(8'h37);
    send(CMD_TOP, 8'h01);
    check_val("top_keeps", 8'h37, wiper.wb_code);
    check_pos("top_aw", POS_LOW, wiper.aw_pos);
    check_pos("top_wb", POS_FULL, wiper.wb_pos);
    send(CMD_INC, 8'h00);
    check_pos("inc_exit", POS_CODE, wiper.wb_pos);
    send(CMD_BOTTOM, 8'h01);
    check_pos("bot_aw", POS_FULL, wiper.aw_pos);
    check_pos("bot_wb", POS_LOW, wiper.wb_pos);
    send(CMD_BOTTOM, 8'h00);
    check_pos("bot_exit", POS_CODE, wiper.wb_pos);
    send(CMD_SHUTDOWN, 8'h01);
    check_pos("sd_aw", POS_OPEN, wiper.aw_pos);
    check_pos("sd_wb", POS_LOW, wiper.wb_pos);
    send(CMD_WR_INPUT, 8'h5A);
    send(CMD_RD_INPUT, 8'h00);
    check_val("sd_accepts", 8'h5A, read_data);
    send(CMD_SHUTDOWN, 8'h00);
    check_pos("sd_exit", POS_CODE, wiper.wb_pos);
    check_val("sd_keeps", 8'h38, wiper.wb_code);
    $display("test scale and shutdown done");
    send(CMD_CONTROL, 8'h02);
    check_val("we_cleared", 8'h02, {4'h0, control});
    preset(8'h11);
    send(CMD_INC, 8'h00);
    check_val("we_frozen", 8'h38, wiper.wb_code);
    send(CMD_CONTROL, 8'h03);
    wp_n = 1'b0;
    repeat (6) @(negedge clk_in);
    preset(8'h22);
    check_val("wp_frozen", 8'h38, wiper.wb_code);
    send(CMD_SWRESET, 8'h00);
    check_val("wp_reload", CODE_MID, wiper.wb_code);
    wp_n = 1'b1;
    repeat (6) @(negedge clk_in);
    send(CMD_WR_INPUT, 8'hA5);
    load_n = 1'b0;
    repeat (8) @(negedge clk_in);
    wait_idle();
    check_val("pin_load", 8'hA5, wiper.wb_code);
    load_n = 1'b1;
    $display("test protection done");
    send(CMD_CONTROL, 8'h07);
    check_val("linear_on", 8'h01, {7'h00, linear});
    sel_aw = 1'b1;
    send(CMD_WR_INPUT, 8'h5C);
    send(CMD_LOAD, 8'h00);
    sel_aw = 1'b0;
    check_val("lin_aw_load", 8'h5C, wiper.aw_code);
    check_val("lin_wb_kept", 8'hA5, wiper.wb_code);
    send(CMD_TOP, 8'h01);
    check_pos("lin_top_aw", POS_FULL, wiper.aw_pos);
    check_pos("lin_top_wb", POS_FULL, wiper.wb_pos);
    send(CMD_TOP, 8'h00);
    check_val("lin_keeps", 8'hA5, wiper.wb_code);
    send(CMD_SHUTDOWN, 8'h01);
    check_pos("lin_sd_wb", POS_OPEN, wiper.wb_pos);
    send(CMD_SHUTDOWN, 8'h00);
    all_ch = 1'b1;
    send(CMD_INC, 8'h00);
    all_ch = 1'b0;
    check_val("all_inc_wb", 8'hA6, wiper.wb_code);
    check_val("all_inc_aw", 8'h5D, wiper.aw_code);
    send(CMD_CONTROL, 8'h0F);
    check_val("burst_on", 8'h0F, {4'h0, control});
    send(CMD_INC, 8'h00);
    check_val("burst_active", 8'h01, {7'h00, burst});
    frame = 1'b0;
    send(CMD_DEC, 8'h00);
    check_val("burst_reuse", 8'hA8, wiper.wb_code);
    frame = 1'b1;
    send(CMD_DEC, 8'h00);
    check_val("burst_new_cmd", 8'hA7, wiper.wb_code);
    rst_n = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_n = 1'b1;
    wait_idle();
    check_val("pin_reset", CODE_MID, wiper.wb_code);
    check_val("pin_reset_ctl", 8'h07, {4'h0, control});
    check_val("pin_reset_burst", 8'h00, {7'h00, burst});
    independent_mode_pin = 1'b1;
    reset_in = 1'b1;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    wait_idle();
    check_val("burst_reset", {4'h0, CTL_RESET}, {4'h0, control});
    check_val("reset_wiper", CODE_MID, wiper.wb_code);
    check_val("independent_mode_pin_linear", 8'h01, {7'h00, linear});
    check_val("independent_mode_pin_aw", 8'h3C, wiper.aw_code);
    $display("test modes done");
    tally_and_finish();
  end
endmodule
